// File: gdp4_pkg.sv
/*
 * Shared constants for the four-port data-register block: register offsets,
 * widths, reset values, mode encodings, bus response codes.
 * Assumes an AXI4-Lite register bus with 32-bit data.
 */
package gdp4_pkg;
    localparam int          PORT_W     = 8;
    localparam int          NUM_PORTS  = 4;
    localparam int          ADDR_W     = 6;
    localparam int          DATA_W     = 32;
    localparam int          MODE_W     = 2;
    localparam int          SYNC_W     = 3;
    localparam int          PIN5       = 5;
    localparam int          MODE_HI    = 1;
    localparam int          MODE_LO    = 0;
    // Data registers
    localparam logic [5:0]  OFF_DATA_A = 6'h00;
    localparam logic [5:0]  OFF_DATA_B = 6'h04;
    localparam logic [5:0]  OFF_DATA_C = 6'h08;
    localparam logic [5:0]  OFF_DATA_D = 6'h0C;
    // Mode registers, two bits per pin
    localparam logic [5:0]  OFF_CFG_A  = 6'h10;
    localparam logic [5:0]  OFF_CFG_B  = 6'h14;
    localparam logic [5:0]  OFF_CFG_C  = 6'h18;
    localparam logic [5:0]  OFF_CFG_D  = 6'h1C;
    localparam logic [7:0]  DATA_RST   = 8'h00;
    localparam logic [15:0] CFG_RST    = 16'h0000;
    localparam logic [1:0]  MODE_OTHER = 2'h0;
    localparam logic [1:0]  MODE_OUT   = 2'h1;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// File: gdp4_pin_sync.sv
/*
 * Three-stage synchroniser for one 8-bit port's pin levels; a bit's filtered
 * value changes only once stages two and three agree.
 * Assumes pin levels are asynchronous to aclk.
 */
`timescale 1ns/1ps
module gdp4_pin_sync (
    input  wire logic       aclk,     // System clock
    input  wire logic       aresetn,  // Sync reset, active low
    input  wire logic [7:0] pin_in,   // Raw pin levels
    output logic      [7:0] pin_lvl   // Filtered pin levels
);
    logic [7:0] s1_ff;
    logic [7:0] s2_ff;
    logic [7:0] s3_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_ff <= gdp4_pkg::DATA_RST;
            s2_ff <= gdp4_pkg::DATA_RST;
            s3_ff <= gdp4_pkg::DATA_RST;
        end
        else
        begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    genvar i;
    generate
        for (i = 0; i < gdp4_pkg::PORT_W; i++)
        begin : g_bit
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    pin_lvl[i] <= 1'b0;
                else if (s2_ff[i] == s3_ff[i])
                    pin_lvl[i] <= s3_ff[i];
            end
        end
    endgenerate
endmodule

// File: gdp4_gpio_data_ports.sv
/*
 * Data-register side of four 8-bit general-purpose ports A to D, with per-pin
 * mode registers, pin drive, pull-up control and an AXI4-Lite slave.
 * Assumes one clock, a synchronous active-low reset and outside pad cells
 * that resolve the output enables and pull-up requests.
 */
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module gdp4_gpio_data_ports (
    input  wire logic        aclk,          // System clock, 20 MHz
    input  wire logic        aresetn,       // Sync reset, active low
    input  wire logic [5:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [5:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    input  wire logic [31:0] port_pin_in,   // Pin levels, 8 per port, A low
    output logic      [31:0] port_pin_out,  // Pin drive values
    output logic      [31:0] port_pin_oe,   // Pin output enables
    output logic      [31:0] port_pullup_en,// Pull-up enables
    output logic             pin5_dedicated_function_sel // Port D pin 5 in mode 00
);
    localparam int PW = gdp4_pkg::PORT_W;
    localparam int NP = gdp4_pkg::NUM_PORTS;

    logic [NP-1:0][PW-1:0]   data_ff;
    logic [NP-1:0][2*PW-1:0] cfg_ff;
    logic [NP-1:0][PW-1:0]   pin_lvl;
    logic [NP-1:0][PW-1:0]   rd_view;
    logic [NP-1:0][PW-1:0]   oe_v;
    logic [NP-1:0][PW-1:0]   pu_v;

    logic       aw_got_ff;
    logic       w_got_ff;
    logic [5:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic       bvalid_ff;
    logic [1:0] bresp_ff;
    logic       rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic       do_write;

    genvar p, b;
    generate
        for (p = 0; p < NP; p++)
        begin : g_port
            gdp4_pin_sync u_sync (
                .aclk    (aclk),
                .aresetn (aresetn),
                .pin_in  (port_pin_in[p*PW +: PW]),
                .pin_lvl (pin_lvl[p])
            );
            for (b = 0; b < PW; b++)
            begin : g_bit
                logic [1:0] md;
                assign md = cfg_ff[p][2*b +: gdp4_pkg::MODE_W];
                // Read view per mode high bit
                assign rd_view[p][b] = md[gdp4_pkg::MODE_HI] ? pin_lvl[p][b]
                                                             : data_ff[p][b];
                // Port D pin 5 has no port output; mode 01 there never drives
                if (p == NP - 1 && b == gdp4_pkg::PIN5)
                begin : g_nf
                    assign oe_v[p][b] = 1'b0;
                end
                else
                begin : g_std
                    assign oe_v[p][b] = (md == gdp4_pkg::MODE_OUT);
                end
                assign pu_v[p][b] = md[gdp4_pkg::MODE_HI]
                                    & ~md[gdp4_pkg::MODE_LO];
            end
        end
    endgenerate

    assign port_pin_out   = data_ff;
    assign port_pin_oe    = oe_v;
    assign port_pullup_en = pu_v;
    assign pin5_dedicated_function_sel =
        (cfg_ff[NP-1][2*gdp4_pkg::PIN5 +: gdp4_pkg::MODE_W] == gdp4_pkg::MODE_OTHER);

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready  = !w_got_ff && !bvalid_ff;
    assign do_write      = aw_got_ff && w_got_ff && !bvalid_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff <= 1'b0;
            awaddr_ff <= 6'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end
        else if (do_write)
            aw_got_ff <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_got_ff <= 1'b0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
        else if (do_write)
            w_got_ff <= 1'b0;
    end

    // Register writes; data stored in every mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < NP; i++)
            begin
                data_ff[i] <= gdp4_pkg::DATA_RST;
                cfg_ff[i]  <= gdp4_pkg::CFG_RST;
            end
        end
        else if (do_write)
        begin
            for (int i = 0; i < NP; i++)
            begin
                if (awaddr_ff[5:2] == gdp4_pkg::OFF_DATA_A[5:2] + 4'(i) && wstrb_ff[0])
                    data_ff[i] <= wdata_ff[PW-1:0];
                if (awaddr_ff[5:2] == gdp4_pkg::OFF_CFG_A[5:2] + 4'(i))
                begin
                    if (wstrb_ff[0])
                        cfg_ff[i][7:0] <= wdata_ff[7:0];
                    if (wstrb_ff[1])
                        cfg_ff[i][15:8] <= wdata_ff[15:8];
                end
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= gdp4_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (awaddr_ff[5] == 1'b0) ? gdp4_pkg::RESP_OKAY
                                                : gdp4_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_ff <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // Read channel
    assign s_axi_arready = !rvalid_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= gdp4_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= gdp4_pkg::RESP_OKAY;
            case (s_axi_araddr[5:2])
                gdp4_pkg::OFF_DATA_A[5:2]: rdata_ff[PW-1:0] <= rd_view[0];
                gdp4_pkg::OFF_DATA_B[5:2]: rdata_ff[PW-1:0] <= rd_view[1];
                gdp4_pkg::OFF_DATA_C[5:2]: rdata_ff[PW-1:0] <= rd_view[2];
                gdp4_pkg::OFF_DATA_D[5:2]: rdata_ff[PW-1:0] <= rd_view[3];
                gdp4_pkg::OFF_CFG_A[5:2]:  rdata_ff[15:0]   <= cfg_ff[0];
                gdp4_pkg::OFF_CFG_B[5:2]:  rdata_ff[15:0]   <= cfg_ff[1];
                gdp4_pkg::OFF_CFG_C[5:2]:  rdata_ff[15:0]   <= cfg_ff[2];
                gdp4_pkg::OFF_CFG_D[5:2]:  rdata_ff[15:0]   <= cfg_ff[3];
                default:                   rresp_ff <= gdp4_pkg::RESP_SLVERR;
            endcase
        end
        else if (s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;
endmodule

// File: gdp4_gpio_data_ports_sva.sv
/* Assertions on the four-port block's outputs.
   Bound to gdp4_gpio_data_ports; sees its ports only. */
`timescale 1ns/1ps
module gdp4_dp_sva (
    input wire logic        aclk,           // Clock
    input wire logic        aresetn,        // Reset, low
    input wire logic        s_axi_awvalid,  // AW valid
    input wire logic        s_axi_awready,  // AW ready
    input wire logic        s_axi_wvalid,   // W valid
    input wire logic        s_axi_wready,   // W ready
    input wire logic        s_axi_bvalid,   // B valid
    input wire logic        s_axi_rvalid,   // R valid
    input wire logic        s_axi_rready,   // R ready
    input wire logic [31:0] port_pin_out,   // Drive
    input wire logic [31:0] port_pin_oe,    // Enables
    input wire logic [31:0] port_pullup_en, // Pull-ups
    input wire logic        pin5_dedicated_function_sel // Pin 5 select
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_reset_clear: assert property ($rose(aresetn) |-> port_pin_out == 32'h0
        && port_pin_oe == 32'h0 && pin5_dedicated_function_sel) else $error("reset state");
    chk_drive_excl: assert property ((port_pin_oe & port_pullup_en) == 32'h0)
        else $error("drive and pull-up together");
    chk_pin5_nodrive: assert property (!port_pin_oe[29]) else $error("pin 5 driven");
    chk_pin5_sel: assert property (pin5_dedicated_function_sel |-> !port_pullup_en[29])
        else $error("pin 5 pull-up in mode 00");
    chk_out_by_write: assert property ($past(aresetn) && $changed(port_pin_out)
        |-> $rose(s_axi_bvalid)) else $error("drive moved without write");
    chk_oe_by_write: assert property ($past(aresetn) && ($changed(port_pin_oe)
        || $changed(port_pullup_en)) |-> $rose(s_axi_bvalid)) else $error("mode moved");
    chk_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write response");
    chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answered twice");
endmodule
bind gdp4_gpio_data_ports gdp4_dp_sva gdp4_dp_sva_inst (.*);

// File: gdp4_pin_model.sv
/* External pins of the four ports: pads, pull-ups, outside drivers.
   Needs the block's drive, enable and pull-up outputs. */
`timescale 1ns/1ps
module gdp4_pin_model (
    input  wire logic        aclk,      // Clock
    input  wire logic [31:0] pin_out,   // Block drive
    input  wire logic [31:0] pin_oe,    // Block enables
    input  wire logic [31:0] pullup_en, // Pull-up requests
    input  wire logic [31:0] ext_val,   // Outside value
    input  wire logic [31:0] ext_en,    // Outside enable
    output logic      [31:0] pin_lvl    // Resolved levels
);
    logic [31:0] float_ff = 32'h0;
    // Floating pins toggle every edge, so the synchroniser filter keeps their last settled level
    always_ff @(posedge aclk) float_ff <= ~float_ff;
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pullup_en | float_ff));
endmodule

// File: gdp4_gpio_data_ports_bench.sv
/* Self-checking bench for the four-port data-register block.
   Drives AXI4-Lite and the pin model; compares with a model. */
`timescale 1ns/1ps
module gdp4_gpio_data_ports_bench;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, ext_val = 32'h0, ext_en = 32'h0, lfsr = 32'h92DF;
    logic [3:0]  strb = 4'hF;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, sel;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, pin_in, pin_out, pin_oe, pu_en, got, v;
    int          failures = 0, num_checks = 0;
    int          dreg [4] = '{0, 0, 0, 0};
    int          mreg [4] = '{0, 0, 0, 0};
    gdp4_gpio_data_ports gdp4_gpio_data_ports_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe(pin_oe),
        .port_pullup_en(pu_en), .pin5_dedicated_function_sel(sel));
    gdp4_pin_model gdp4_pin_model_inst (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pu_en), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_in));
    always #25 aclk = ~aclk;
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        check({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [5:0] a, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        got = rdata;
        check({30'h0, rresp}, {30'h0, er});
    endtask
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // k: 0 read view, 1 enables, 2 pull-ups, 3 drive
    function automatic logic [31:0] mode_map(input int k);
        logic [31:0] r;
        int m;
        r = 32'h0;
        for (int i = 0; i < 32; i++)
        begin
            m = (mreg[i / 8] >> (2 * (i % 8))) & 3;
            if (k == 1) r[i] = (m == 1) && (i != 29);
            else if (k == 2) r[i] = (m == 2);
            else if (k == 3 || m < 2) r[i] = dreg[i / 8][i % 8];
            // Undriven pull-up pins read high
            else r[i] = (m == 2) | ext_val[i];
        end
        return r;
    endfunction
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        for (int p = 0; p < 8; p++)
        begin
            rd(6'(4 * p), 2'h0);
            check(got, 32'h0);
        end
        check(pin_oe | pu_en, 32'h0);
        for (int t = 0; t < 16; t++)
        begin
            for (int p = 0; p < 4; p++)
            begin
                v = rnd() & 32'hFFFF;
                if (p == 3 && v[11:10] == 2'h1) v[10] = 1'h0;
                mreg[p] = v;
                wr(6'h10 + 6'(4 * p), v, gdp4_pkg::RESP_OKAY);
                v = rnd() & 32'hFF;
                dreg[p] = v;
                wr(6'(4 * p), v, gdp4_pkg::RESP_OKAY);
            end
            // Pull-up pins left undriven so only the pull-up sets their level
            ext_en <= ~mode_map(1) & ~mode_map(2);
            ext_val <= rnd();
            // Synchroniser needs about four edges
            repeat (6) @(posedge aclk);
            check(pin_oe, mode_map(1));
            check(pu_en, mode_map(2));
            check(pin_out, mode_map(3));
            check({31'h0, sel}, {31'h0, mreg[3][11:10] == 2'h0});
            for (int p = 0; p < 4; p++)
            begin
                rd(6'(4 * p), 2'h0);
                v = mode_map(0);
                check(got, {24'h0, v[8 * p +: 8]});
            end
        end
        // Byte 0 strobe off: data register keeps its value
        strb <= 4'hE;
        wr(6'h00, 32'hA5, gdp4_pkg::RESP_OKAY);
        strb <= 4'hF;
        wr(6'h20, 32'hFF, gdp4_pkg::RESP_SLVERR);
        rd(6'h3C, gdp4_pkg::RESP_SLVERR);
        check(got | pin_out ^ mode_map(3), 32'h0);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        check(pin_out | pin_oe | {31'h0, !sel}, 32'h0);
        rd(6'h00, 2'h0);
        check(got, 32'h0);
        end_sim();
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        failures++;
        end_sim();
    end
endmodule
